// ### verilog/adcrl_pkg.sv
// Constants shared by the result list manager files
package adcrl_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int RAW_W = 12;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 24;
    localparam int INDEX_W = 16;
    localparam int CMD_INDEX_W = 8;
    localparam int ENTRY_W = ADDR_W + WORD_W;

    // ************************************************************
    // Resolution codes and justification
    // ************************************************************
    localparam logic [1:0] RES_8 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_12 = 2'h2;
    localparam logic JUSTIFY_LEFT = 1'h0;
    localparam logic JUSTIFY_RIGHT = 1'h1;

    // Field positions inside one buffered entry
    localparam int ENTRY_DATA_LSB = 0;
    localparam int ENTRY_ADDR_LSB = WORD_W;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [ADDR_W-1:0] BASE_RESET = 24'h000000;
    localparam logic [ADDR_W-1:0] OFFSET_RESET = 24'h000000;
    localparam logic [INDEX_W-1:0] INDEX_RESET = 16'h0000;
    localparam logic [CMD_INDEX_W-1:0] CMD_INDEX_RESET = 8'h00;
    localparam logic LIST_SEL_RESET = 1'h0;
endpackage

// ### verilog/adcrl_format.sv
// Justification of one raw conversion result into a 16-bit word
`timescale 1ns/1ps
module adcrl_format
    import adcrl_pkg::*;
(
    input wire logic [RAW_W-1:0] raw,
    input wire logic [1:0] resolution_select,
    input wire logic justify_select,
    output logic [WORD_W-1:0] word
);
    // ************************************************************
    // Formatting
    // ************************************************************
    // Unused positions stay zero; code 3 is treated as 12 bit
    always_comb
    begin
        word = 16'h0000;
        if (resolution_select == RES_8)
        begin
            if (justify_select == JUSTIFY_RIGHT)
                word = {8'h00, raw[7:0]};
            else
                word = {raw[7:0], 8'h00};
        end
        else if (resolution_select == RES_10)
        begin
            if (justify_select == JUSTIFY_RIGHT)
                word = {6'h00, raw[9:0]};
            else
                word = {raw[9:0], 6'h00};
        end
        else
        begin
            if (justify_select == JUSTIFY_RIGHT)
                word = {4'h0, raw[11:0]};
            else
                word = {raw[11:0], 4'h0};
        end
    end
endmodule

// ### verilog/adcrl_skid.sv
// Two-entry buffer between the result path and system memory
`timescale 1ns/1ps
module adcrl_skid
    import adcrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [ENTRY_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [ENTRY_W-1:0] out_data
);
    logic skid_valid;
    logic [ENTRY_W-1:0] skid_data;
    logic next_out_valid;
    logic [ENTRY_W-1:0] next_out_data;
    logic next_skid_valid;
    logic [ENTRY_W-1:0] next_skid_data;
    logic next_in_ready;

    // ************************************************************
    // Next state
    // ************************************************************
    // Ready is registered so the source never sees a combinational path
    always_comb
    begin
        next_out_valid = out_valid;
        next_out_data = out_data;
        next_skid_valid = skid_valid;
        next_skid_data = skid_data;
        if (!out_valid || out_ready)
        begin
            if (skid_valid)
            begin
                next_out_valid = 1'b1;
                next_out_data = skid_data;
                next_skid_valid = 1'b0;
            end
            else
            begin
                next_out_valid = in_valid && in_ready;
                if (in_valid && in_ready)
                    next_out_data = in_data;
            end
        end
        else if (in_valid && in_ready)
        begin
            next_skid_valid = 1'b1;
            next_skid_data = in_data;
        end
        next_in_ready = !next_skid_valid;
    end

    // Registers
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            out_valid <= 1'b0;
            out_data <= '0;
            skid_valid <= 1'b0;
            skid_data <= '0;
            in_ready <= 1'b0;
        end
        else if (clk_en)
        begin
            out_valid <= next_out_valid;
            out_data <= next_out_data;
            skid_valid <= next_skid_valid;
            skid_data <= next_skid_data;
            in_ready <= next_in_ready;
        end
    end
endmodule

// ### verilog/adcrl_manager.sv
// Result list manager: formatting, list indices, buffer switching, lock
`timescale 1ns/1ps
module adcrl_manager
    import adcrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic adc_enable,
    input wire logic justify_select,
    input wire logic [1:0] resolution_select,
    input wire logic command_list_buffer_mode,
    input wire logic result_list_buffer_mode,
    input wire logic sw_base_write,
    input wire logic sw_offset0_write,
    input wire logic sw_offset1_write,
    input wire logic sw_index_write,
    input wire logic [ADDR_W-1:0] sw_pointer_data,
    input wire logic [INDEX_W-1:0] sw_index_data,
    input wire logic command_advance,
    input wire logic restart_at_boundary,
    input wire logic conversion_abort,
    input wire logic conv_valid,
    output logic conv_ready,
    input wire logic [RAW_W-1:0] conv_data,
    input wire logic conv_end_of_list,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [ADDR_W-1:0] mem_wr_addr,
    output logic [WORD_W-1:0] mem_wr_data,
    output logic result_list_select,
    output logic command_list_select,
    output logic [ADDR_W-1:0] result_base_pointer,
    output logic [ADDR_W-1:0] result_list_offset0,
    output logic [ADDR_W-1:0] result_list_offset1,
    output logic [INDEX_W-1:0] result_index,
    output logic [CMD_INDEX_W-1:0] command_index,
    output logic last_full_list_indicator
);
    // ************************************************************
    // Declarations
    // ************************************************************
    logic [WORD_W-1:0] fmt_data;
    logic store;
    logic list_clear;
    logic pending_switch;
    logic eff_sel;
    logic [INDEX_W-1:0] eff_index;
    logic [ADDR_W-1:0] store_addr;
    logic [ENTRY_W-1:0] buf_in_data;
    logic [ENTRY_W-1:0] buf_out_data;
    logic next_pending_switch;
    logic next_result_list_select;
    logic next_command_list_select;
    logic [ADDR_W-1:0] next_result_base_pointer;
    logic [ADDR_W-1:0] next_result_list_offset0;
    logic [ADDR_W-1:0] next_result_list_offset1;
    logic [INDEX_W-1:0] next_result_index;
    logic [CMD_INDEX_W-1:0] next_command_index;
    logic next_last_full_list_indicator;

    // ************************************************************
    // Result formatting and buffering
    // ************************************************************
    adcrl_format u_format (
        .raw(conv_data),
        .resolution_select(resolution_select),
        .justify_select(justify_select),
        .word(fmt_data)
    );

    // Results offered while disabled are accepted and dropped
    assign store = conv_valid && conv_ready && adc_enable;

    // Single mode clears on restart and abort immediately
    assign list_clear = !result_list_buffer_mode && (restart_at_boundary || conversion_abort);

    // In double mode the first result after a finished or aborted list opens the other list
    assign eff_sel = pending_switch ? !result_list_select : result_list_select;
    assign eff_index = pending_switch ? INDEX_RESET : result_index;

    // Index counts 16-bit words, so the byte address steps by two
    assign store_addr = ADDR_W'(result_base_pointer + (eff_sel ? result_list_offset1 : result_list_offset0)
        + {eff_index, 1'b0});
    assign buf_in_data = {store_addr, fmt_data};

    adcrl_skid u_skid (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(conv_valid && adc_enable),
        .in_ready(conv_ready),
        .in_data(buf_in_data),
        .out_valid(mem_wr_valid),
        .out_ready(mem_wr_ready),
        .out_data(buf_out_data)
    );

    // Split the buffered entry back into address and word
    assign mem_wr_addr = buf_out_data[ENTRY_ADDR_LSB +: ADDR_W];
    assign mem_wr_data = buf_out_data[ENTRY_DATA_LSB +: WORD_W];

    // ************************************************************
    // Pointer registers
    // ************************************************************
    // Software writes only land while the converter is off
    always_comb
    begin
        next_result_base_pointer = result_base_pointer;
        next_result_list_offset0 = result_list_offset0;
        next_result_list_offset1 = result_list_offset1;
        if (!adc_enable)
        begin
            if (sw_base_write)
                next_result_base_pointer = sw_pointer_data;
            if (sw_offset0_write)
                next_result_list_offset0 = sw_pointer_data;
            if (sw_offset1_write)
                next_result_list_offset1 = sw_pointer_data;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            result_base_pointer <= BASE_RESET;
            result_list_offset0 <= OFFSET_RESET;
            result_list_offset1 <= OFFSET_RESET;
        end
        else if (clk_en)
        begin
            result_base_pointer <= next_result_base_pointer;
            result_list_offset0 <= next_result_list_offset0;
            result_list_offset1 <= next_result_list_offset1;
        end
    end

    // ************************************************************
    // List indices and selection
    // ************************************************************
    // Clears win over a store in the same cycle, the store itself still lands
    always_comb
    begin
        next_pending_switch = pending_switch;
        next_result_list_select = result_list_select;
        next_command_list_select = command_list_select;
        next_result_index = result_index;
        next_command_index = command_index;
        next_last_full_list_indicator = last_full_list_indicator;
        if (!adc_enable)
        begin
            if (sw_index_write)
                next_result_index = sw_index_data;
        end
        else
        begin
            if (command_advance)
                next_command_index = CMD_INDEX_W'(command_index + 8'h01);
            if (store)
            begin
                next_result_list_select = eff_sel;
                next_result_index = INDEX_W'(eff_index + 16'h0001);
                next_pending_switch = 1'b0;
                if (conv_end_of_list)
                begin
                    next_last_full_list_indicator = eff_sel;
                    next_pending_switch = 1'b1;
                    if (command_list_buffer_mode)
                        next_command_list_select = !command_list_select;
                    if (!result_list_buffer_mode)
                    begin
                        next_result_index = INDEX_RESET;
                        next_command_index = CMD_INDEX_RESET;
                    end
                end
            end
            // An abort in double mode arms the switch; set beats the store's clear
            if (conversion_abort && result_list_buffer_mode)
                next_pending_switch = 1'b1;
            if (restart_at_boundary || conversion_abort)
                next_command_index = CMD_INDEX_RESET;
            if (list_clear)
                next_result_index = INDEX_RESET;
        end
        // Single result buffering pins the result select to the first list; single command buffering pins the command select
        if (!result_list_buffer_mode)
        begin
            next_result_list_select = LIST_SEL_RESET;
            next_last_full_list_indicator = LIST_SEL_RESET;
            next_pending_switch = 1'b0;
        end
        if (!command_list_buffer_mode)
            next_command_list_select = LIST_SEL_RESET;
    end

    // Index and pointers are plain outputs, readable while running
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pending_switch <= 1'b0;
            result_list_select <= LIST_SEL_RESET;
            command_list_select <= LIST_SEL_RESET;
            result_index <= INDEX_RESET;
            command_index <= CMD_INDEX_RESET;
            last_full_list_indicator <= LIST_SEL_RESET;
        end
        else if (clk_en)
        begin
            pending_switch <= next_pending_switch;
            result_list_select <= next_result_list_select;
            command_list_select <= next_command_list_select;
            result_index <= next_result_index;
            command_index <= next_command_index;
            last_full_list_indicator <= next_last_full_list_indicator;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    single_sel_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !result_list_buffer_mode && !command_list_buffer_mode)
        |=> (!result_list_select && !command_list_select))
        else $error("list select not forced low in single mode");

    ptr_lock_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && adc_enable && (sw_base_write || sw_offset0_write || sw_offset1_write || sw_index_write)
            && !store && !list_clear)
        |=> ($stable(result_base_pointer) && $stable(result_list_offset0) && $stable(result_list_offset1)
            && $stable(result_index)))
        else $error("pointer changed by software while enabled");

    idx_step_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && store && !pending_switch && !conv_end_of_list && !list_clear)
        |=> (result_index == INDEX_W'($past(result_index) + 16'h0001)))
        else $error("result index did not step by one");

    word_layout_a: assert property (@(posedge sys_clk) disable iff (rst)
        store |-> (buf_in_data[WORD_W-1:0] == fmt_data && buf_in_data[ENTRY_W-1:WORD_W] == store_addr))
        else $error("buffered entry does not hold the formatted word");

    pad_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        (resolution_select == RES_8 && justify_select == JUSTIFY_RIGHT) |-> (fmt_data[15:8] == 8'h00))
        else $error("unused upper bits not zero");

    left_just_a: assert property (@(posedge sys_clk) disable iff (rst)
        (resolution_select == RES_12 && justify_select == JUSTIFY_LEFT)
        |-> (fmt_data == {conv_data[11:0], 4'h0}))
        else $error("12 bit left justification wrong");

    single_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && adc_enable && !result_list_buffer_mode && (conversion_abort || (store && conv_end_of_list)))
        |=> (result_index == INDEX_RESET && command_index == CMD_INDEX_RESET))
        else $error("indices not cleared in single mode");

    list_switch_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && store && pending_switch && result_list_buffer_mode && !conversion_abort)
        |=> (result_list_select != $past(result_list_select) && result_index == 16'h0001))
        else $error("result list did not switch on first result");

    last_full_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && store && conv_end_of_list && result_list_buffer_mode)
        |=> (last_full_list_indicator == $past(eff_sel)))
        else $error("last full list indicator wrong");

    // A 10 bit right justified word keeps the raw bits at the bottom
    right_just_a: assert property (@(posedge sys_clk) disable iff (rst)
        (resolution_select == RES_10 && justify_select == JUSTIFY_RIGHT)
        |-> (fmt_data == {6'h00, conv_data[9:0]}))
        else $error("10 bit right justification wrong");

    // Left justified 8 bit results must not leak into the low bits
    pad_left_a: assert property (@(posedge sys_clk) disable iff (rst)
        (resolution_select == RES_8 && justify_select == JUSTIFY_LEFT) |-> (fmt_data[7:0] == 8'h00))
        else $error("unused lower bits not zero");

    // Abort in double mode must arm the switch even without a store
    abort_arm_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && adc_enable && conversion_abort && result_list_buffer_mode)
        |=> pending_switch)
        else $error("abort did not arm the list switch");

    // With the converter stopped a software write lands next cycle
    sw_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && !adc_enable && sw_base_write)
        |=> (result_base_pointer == $past(sw_pointer_data)))
        else $error("base pointer write did not land while stopped");
endmodule

// ### sim/adcrl_mem_model.sv
// System memory model that sinks result words with random stalls
`timescale 1ns/1ps
module adcrl_mem_model
    import adcrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic stall_en,
    input wire logic mem_wr_valid,
    output logic mem_wr_ready,
    input wire logic [ADDR_W-1:0] mem_wr_addr,
    input wire logic [WORD_W-1:0] mem_wr_data
);
    logic [WORD_W-1:0] store [logic [ADDR_W-1:0]];

    // Ready moves off the sampling edge; random stalls let the buffer fill up
    initial mem_wr_ready = 1'b0;
    always @(negedge sys_clk)
    begin
        mem_wr_ready <= rst ? 1'b0 : (stall_en ? 1'($urandom % 2) : 1'b1);
    end

    // A word lands on the edge where valid meets ready
    always @(posedge sys_clk)
    begin
        if (!rst && mem_wr_valid && mem_wr_ready)
        begin
            store[mem_wr_addr] = mem_wr_data;
        end
    end

    // Read back at any moment, also while stores are under way
    function automatic logic [WORD_W-1:0] peek(logic [ADDR_W-1:0] a);
        return store.exists(a) ? store[a] : 16'hffff;
    endfunction
endmodule

// ### sim/adcrl_manager_bench.sv
// Self-checking bench for the result list manager
`timescale 1ns/1ps
module adcrl_manager_bench
    import adcrl_pkg::*;
;
    logic sys_clk, rst, clk_en, adc_enable, justify_select, command_list_buffer_mode, result_list_buffer_mode;
    logic [1:0] resolution_select;
    logic sw_base_write, sw_offset0_write, sw_offset1_write, sw_index_write;
    logic [ADDR_W-1:0] sw_pointer_data;
    logic [INDEX_W-1:0] sw_index_data;
    logic command_advance, restart_at_boundary, conversion_abort, conv_valid, conv_ready, conv_end_of_list;
    logic [RAW_W-1:0] conv_data;
    logic mem_wr_valid, mem_wr_ready, stall_en;
    logic [ADDR_W-1:0] mem_wr_addr, result_base_pointer, result_list_offset0, result_list_offset1;
    logic [WORD_W-1:0] mem_wr_data;
    logic result_list_select, command_list_select, last_full_list_indicator;
    logic [INDEX_W-1:0] result_index;
    logic [CMD_INDEX_W-1:0] command_index;
    logic [ENTRY_W-1:0] exp_q[$];
    logic [ENTRY_W-1:0] last_word;
    int bad_count, num_checks;
    int m_base, m_off0, m_off1, m_idx, m_cmd, m_sel, m_pend, m_last, m_csel;

    adcrl_manager adcrl_manager_inst (.sys_clk, .rst, .clk_en, .adc_enable, .justify_select, .resolution_select,
        .command_list_buffer_mode, .result_list_buffer_mode, .sw_base_write, .sw_offset0_write, .sw_offset1_write,
        .sw_index_write, .sw_pointer_data, .sw_index_data, .command_advance, .restart_at_boundary,
        .conversion_abort, .conv_valid, .conv_ready, .conv_data, .conv_end_of_list, .mem_wr_valid, .mem_wr_ready,
        .mem_wr_addr, .mem_wr_data, .result_list_select, .command_list_select, .result_base_pointer,
        .result_list_offset0, .result_list_offset1, .result_index, .command_index, .last_full_list_indicator);
    adcrl_mem_model adcrl_mem_model_inst (.sys_clk, .rst, .stall_en, .mem_wr_valid, .mem_wr_ready, .mem_wr_addr,
        .mem_wr_data);

    // ************************************************************
    // Helpers
    // ************************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(string what, logic [ENTRY_W-1:0] seen, logic [ENTRY_W-1:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic timeout(string what);
        bad_count++;
        $display("BAD %s expected done seen timeout", what);
        give_verdict();
    endtask

    // Reference justification; unused bits stay zero
    function automatic logic [WORD_W-1:0] fmt(logic [RAW_W-1:0] r, logic [1:0] res, logic j);
        int w;
        int v;
        w = (res == RES_8) ? 8 : (res == RES_10) ? 10 : 12;
        v = int'(r) & ((1 << w) - 1);
        return j ? WORD_W'(v) : WORD_W'(v << (16 - w));
    endfunction

    // Offer one result; the model follows the list rules at the take edge
    task automatic send(logic eol);
        int n;
        logic [RAW_W-1:0] r;
        r = RAW_W'($urandom);
        conv_valid = 1'b1;
        conv_data = r;
        conv_end_of_list = eol;
        n = 0;
        while (conv_ready !== 1'b1)
        begin
            @(negedge sys_clk);
            n++;
            if (n > 50)
                timeout("conv_ready");
        end
        if (m_pend != 0)
        begin
            m_sel ^= 1;
            m_idx = 0;
            m_pend = 0;
        end
        last_word = {ADDR_W'(m_base + (m_sel ? m_off1 : m_off0) + 2 * m_idx), fmt(r, resolution_select, justify_select)};
        exp_q.push_back(last_word);
        m_idx++;
        if (eol)
        begin
            m_last = m_sel;
            if (command_list_buffer_mode)
                m_csel ^= 1;
            if (result_list_buffer_mode)
                m_pend = 1;
            else
            begin
                m_idx = 0;
                m_cmd = 0;
            end
        end
        @(negedge sys_clk);
    endtask

    // Lowering valid in its own step keeps one assignment per time step
    task automatic idle();
        conv_valid = 1'b0;
        conv_end_of_list = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 || mem_wr_valid !== 1'b0)
        begin
            @(negedge sys_clk);
            n++;
            if (n > 300)
                timeout("drain");
        end
    endtask

    task automatic sw_write(int which, int val);
        sw_pointer_data = ADDR_W'(val);
        sw_index_data = INDEX_W'(val);
        case (which)
            0: sw_base_write = 1'b1;
            1: sw_offset0_write = 1'b1;
            2: sw_offset1_write = 1'b1;
            default: sw_index_write = 1'b1;
        endcase
        @(negedge sys_clk);
        {sw_base_write, sw_offset0_write, sw_offset1_write, sw_index_write} = 4'h0;
        // Idle edge so the next call never reassigns a strobe in this step
        @(negedge sys_clk);
        if (!adc_enable)
        begin
            case (which)
                0: m_base = val;
                1: m_off0 = val;
                2: m_off1 = val;
                default: m_idx = val;
            endcase
        end
    endtask

    // 0 advance, 1 restart, 2 abort
    task automatic event_pulse(int which);
        case (which)
            0: command_advance = 1'b1;
            1: restart_at_boundary = 1'b1;
            default: conversion_abort = 1'b1;
        endcase
        @(negedge sys_clk);
        {command_advance, restart_at_boundary, conversion_abort} = 3'h0;
        @(negedge sys_clk);
        if (which == 0)
            m_cmd++;
        else
            m_cmd = 0;
        if (which != 0 && !result_list_buffer_mode)
            m_idx = 0;
        else if (which == 2)
            m_pend = 1;
    endtask

    task automatic check_ptrs();
        check("base", ENTRY_W'(result_base_pointer), ENTRY_W'(ADDR_W'(m_base)));
        check("offset0", ENTRY_W'(result_list_offset0), ENTRY_W'(ADDR_W'(m_off0)));
        check("offset1", ENTRY_W'(result_list_offset1), ENTRY_W'(ADDR_W'(m_off1)));
        check("index", ENTRY_W'(result_index), ENTRY_W'(INDEX_W'(m_idx)));
        check("command index", ENTRY_W'(command_index), ENTRY_W'(CMD_INDEX_W'(m_cmd)));
        check("list select", ENTRY_W'(result_list_select), ENTRY_W'(m_sel));
        check("command select", ENTRY_W'(command_list_select), ENTRY_W'(m_csel));
        check("last full", ENTRY_W'(last_full_list_indicator), ENTRY_W'(m_last));
    endtask

    // Every word reaching memory is compared with the reference queue
    always @(posedge sys_clk)
    begin
        if (!rst && mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("extra word", {mem_wr_addr, mem_wr_data}, 40'h0);
            else
                check("stored word", {mem_wr_addr, mem_wr_data}, exp_q.pop_front());
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        {clk_en, adc_enable, justify_select, command_list_buffer_mode, result_list_buffer_mode} = 5'h10;
        {sw_base_write, sw_offset0_write, sw_offset1_write, sw_index_write, stall_en} = 5'h0;
        {command_advance, restart_at_boundary, conversion_abort, conv_valid, conv_end_of_list} = 5'h0;
        {resolution_select, sw_pointer_data, sw_index_data, conv_data} = 54'h0;
        {m_base, m_off0, m_off1, m_idx, m_cmd, m_sel, m_pend, m_last, m_csel} = '0;
        rst = 1'b1;
        void'($urandom(32'hfa2cddb9));
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        check_ptrs();
        sw_write(0, 24'h001000);
        sw_write(1, 24'h000100);
        sw_write(2, 24'h000800);
        sw_write(3, 16'h0005);
        check_ptrs();
        // Locked while running: these writes must not land
        adc_enable = 1'b1;
        sw_write(0, 24'hfff000);
        sw_write(3, 16'h0077);
        check_ptrs();
        stall_en = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            resolution_select = 2'(k / 2);
            justify_select = 1'(k % 2);
            send(1'b0);
        end
        idle();
        drain();
        check_ptrs();
        check("readback", {last_word[39:16], adcrl_mem_model_inst.peek(last_word[39:16])}, last_word);
        repeat (3) event_pulse(0);
        send(1'b0);
        send(1'b1);
        idle();
        check_ptrs();
        send(1'b0);
        idle();
        event_pulse(1);
        check_ptrs();
        event_pulse(0);
        send(1'b0);
        idle();
        event_pulse(2);
        check_ptrs();
        // Double result lists: switch at the first store after a finish or abort
        result_list_buffer_mode = 1'b1;
        command_list_buffer_mode = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            send(1'b0);
            send(1'b1);
            send(1'b0);
            idle();
            drain();
            check_ptrs();
        end
        // Back to a single command list: its select is pinned low again
        command_list_buffer_mode = 1'b0;
        m_csel = 0;
        event_pulse(2);
        send(1'b0);
        idle();
        drain();
        check_ptrs();
        // Words offered while stopped are dropped
        adc_enable = 1'b0;
        conv_valid = 1'b1;
        repeat (3) @(negedge sys_clk);
        idle();
        drain();
        check_ptrs();
        // Clock enable low freezes state: this write must not land
        clk_en = 1'b0;
        sw_write(1, 24'h000200);
        m_off0 = 24'h000100;
        check_ptrs();
        give_verdict();
    end
endmodule
